// File: hw/cd_upper_pkg.sv
// Constants for the context descriptor upper-field decoder.
// Assumes descriptor bits arrive as one flat vector, bit 0 first.
package cd_upper_pkg;
    // Descriptor field positions
    localparam int FIRST_NS_BIT = 64;
    localparam int FIRST_HAD_BIT = 65;
    localparam int FIRST_BASE_LO = 68;
    localparam int FIRST_BASE_HI = 115;
    localparam int FIRST_HWU_LO = 124;
    localparam int SECOND_NS_BIT = 128;
    localparam int SECOND_HAD_BIT = 129;
    localparam int SECOND_BASE_LO = 132;
    localparam int SECOND_BASE_HI = 179;
    localparam int SECOND_HWU_LO = 188;
    localparam int ATTR_LOW_LO = 192;
    localparam int ATTR_HIGH_LO = 224;
    localparam int AUX_LOW_LO = 256;
    localparam int AUX_HIGH_LO = 288;
    localparam int CD_WIDTH = 320;
    // Address layout
    localparam int ADDR_W = 52;
    localparam int BASE_SHIFT = 4;
    localparam int BASE_FIELD_W = 48;
    localparam int SMALL_GRAN_MAX_BITS = 48;
    localparam int ALIGN52_BITS = 6;
    localparam int FIRST_REV_BASE_BITS = 48;
    // Output size codes
    localparam logic [2:0] SIZE_52 = 3'h6;
    // Granule codes shared by both tables in this block
    localparam logic [1:0] GRAN_4K = 2'h0;
    localparam logic [1:0] GRAN_64K = 2'h1;
    localparam logic [1:0] GRAN_16K = 2'h2;
    // Exception level of the stream
    typedef enum logic [1:0] {LEVEL_NS_EL1, LEVEL_SECURE, LEVEL_HYP, LEVEL_MON} level_t;
    // Device memory types for reserved attribute codes
    localparam logic [1:0] DEV_NGNRNE = 2'h0;
    localparam logic [1:0] DEV_NGNRE = 2'h1;
    localparam logic [1:0] DEV_NGRE = 2'h2;
    localparam logic [1:0] DEV_GRE = 2'h3;
    localparam int ATTR_BYTE_W = 8;
    localparam int ATTR_INDEX_W = 3;
endpackage

// File: hw/table_base_check.sv
// One table base decoder: alignment and legality of a base address.
// Assumes the alignment width is supplied by the walker's geometry logic.
`timescale 1ns/100ps
module table_base_check #(
    parameter int FIELD_W = 48
) (
    // Descriptor field and configuration
    input wire logic [FIELD_W-1:0] baseField,
    input wire logic [5:0] alignBits,
    input wire logic [1:0] granule,
    input wire logic [5:0] outputBits,
    input wire logic is52,
    input wire logic walkDisable,
    input wire logic firstRevision,
    // Results
    output logic [cd_upper_pkg::ADDR_W-1:0] alignedBase,
    output logic baseIllegal
);
    logic [cd_upper_pkg::ADDR_W-1:0] rawBase;
    logic [cd_upper_pkg::ADDR_W-1:0] mask;
    logic [5:0] effAlign;
    logic tooWide;
    logic smallTooWide;
    logic revTooWide;

    // Bits outside the field read as zero
    assign rawBase = {baseField, {cd_upper_pkg::BASE_SHIFT{1'b0}}};
    // 64KB granule with 52-bit output needs at least 64-byte alignment
    always_comb begin
        effAlign = alignBits;
        if (granule == cd_upper_pkg::GRAN_64K && is52 &&
            alignBits < 6'(cd_upper_pkg::ALIGN52_BITS)) begin
            effAlign = 6'(cd_upper_pkg::ALIGN52_BITS);
        end
    end
    assign mask = {cd_upper_pkg::ADDR_W{1'b1}} << effAlign;
    assign alignedBase = rawBase & mask;
    // Range checks run on the raw field, which software wrote
    assign tooWide = (rawBase >> outputBits) != '0;
    assign smallTooWide = (granule != cd_upper_pkg::GRAN_64K) &&
        ((rawBase >> cd_upper_pkg::SMALL_GRAN_MAX_BITS) != '0);
    assign revTooWide = firstRevision &&
        ((rawBase >> cd_upper_pkg::FIRST_REV_BASE_BITS) != '0);
    // A disabled table is never checked
    assign baseIllegal = !walkDisable && (tooWide || smallTooWide || revTooWide);
endmodule // table_base_check

// File: hw/context_descriptor_upper_fields.sv
// Decoder for the upper half of a stage-1 context descriptor.
// Assumes the descriptor word and stream settings come from same-clock logic.
`timescale 1ns/100ps
module context_descriptor_upper_fields #(
    parameter bit HIER_DISABLE_IMPL = 1'b1,
    parameter bit PAGE_HW_ATTR_IMPL = 1'b1,
    parameter bit FIRST_REVISION = 1'b0
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic clkEn,

    // Descriptor load
    input wire logic descValid,
    input wire logic [cd_upper_pkg::CD_WIDTH-1:0] contextDescriptor,

    // Stream configuration
    input wire logic secureStreamEntry,
    input wire cd_upper_pkg::level_t streamExceptionLevel,
    input wire logic [2:0] outputSizeSelect,
    input wire logic firstWalkDisable,
    input wire logic secondWalkDisable,
    input wire logic [1:0] firstGranuleSelect,
    input wire logic [1:0] secondGranuleSelect,
    input wire logic [5:0] firstAlignBits,
    input wire logic [5:0] secondAlignBits,
    input wire logic longFormat,

    // Walker leaf lookup
    input wire logic lookupValid,
    input wire logic lookupSecondTable,
    input wire logic [cd_upper_pkg::ATTR_INDEX_W-1:0] attributeIndex,

    // Decoded descriptor
    output logic decodeValid,
    output logic badDescriptorError,
    output logic abortTransaction,
    output logic [cd_upper_pkg::ADDR_W-1:0] firstTableBase,
    output logic [cd_upper_pkg::ADDR_W-1:0] secondTableBase,
    output logic firstStartNonsecure,
    output logic secondStartNonsecure,
    output logic firstIgnoreHierPerm,
    output logic secondIgnoreHierPerm,
    output logic firstIgnoreLowPermPxn,
    output logic secondIgnoreLowPermPxn,
    output logic [3:0] firstHwUseMask,
    output logic [3:0] secondHwUseMask,
    output logic [31:0] auxAttrLow,
    output logic [31:0] auxAttrHigh,

    // Attribute lookup answer
    output logic attrValid,
    output logic [cd_upper_pkg::ATTR_BYTE_W-1:0] attrByte,
    output logic attrIsReservedDevice,
    output logic [1:0] attrDeviceType
);
    logic [cd_upper_pkg::CD_WIDTH-1:0] cdWord;
    logic cdLoaded;
    logic pendingDecode;
    logic [5:0] outputBits;
    logic is52;
    logic hypOrMon;
    logic hadFirst;
    logic hadSecond;
    logic [cd_upper_pkg::ADDR_W-1:0] next_firstBase;
    logic [cd_upper_pkg::ADDR_W-1:0] next_secondBase;
    logic firstIllegal;
    logic secondIllegal;
    logic reservedSet;
    logic [63:0] attrWords;
    logic [cd_upper_pkg::ATTR_BYTE_W-1:0] next_attrByte;
    logic anyBad;
    logic capSecure;
    cd_upper_pkg::level_t capLevel;
    logic capFirstDisable;
    logic capSecondDisable;
    logic [2:0] capSizeSelect;
    logic [1:0] capFirstGranule;
    logic [1:0] capSecondGranule;
    logic [5:0] capFirstAlign;
    logic [5:0] capSecondAlign;

    // Output size code to a bit count; larger codes clamp to 52, or to 48 in the first revision
    always_comb begin
        unique case (capSizeSelect)
            3'h0: outputBits = 6'd32;
            3'h1: outputBits = 6'd36;
            3'h2: outputBits = 6'd40;
            3'h3: outputBits = 6'd42;
            3'h4: outputBits = 6'd44;
            3'h5: outputBits = 6'd48;
            default: outputBits = FIRST_REVISION ? 6'd48 : 6'd52;
        endcase
    end
    assign is52 = (outputBits == 6'd52);
    assign hypOrMon = (capLevel == cd_upper_pkg::LEVEL_HYP) ||
        (capLevel == cd_upper_pkg::LEVEL_MON);

    // Captured descriptor; decode follows one cycle after capture
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cdWord <= '0;
            cdLoaded <= 1'b0;
            pendingDecode <= 1'b0;
        end else if (clkEn) begin
            pendingDecode <= descValid;
            if (descValid) begin
                cdWord <= contextDescriptor;
                cdLoaded <= 1'b1;
            end
        end
    end

    // Stream security and level, held with their descriptor
    // so the decode never mixes two streams' settings
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            capSecure <= 1'b0;
            capLevel <= cd_upper_pkg::LEVEL_NS_EL1;
        end else if (clkEn && descValid) begin
            capSecure <= secureStreamEntry;
            capLevel <= streamExceptionLevel;
        end
    end

    // Walk disables latched at capture
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            capFirstDisable <= 1'b0;
            capSecondDisable <= 1'b0;
        end else if (clkEn && descValid) begin
            capFirstDisable <= firstWalkDisable;
            capSecondDisable <= secondWalkDisable;
        end
    end

    // Walk geometry; a few flops buy a walker free to move on early
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            capSizeSelect <= '0;
            capFirstGranule <= cd_upper_pkg::GRAN_4K;
            capSecondGranule <= cd_upper_pkg::GRAN_4K;
            capFirstAlign <= '0;
            capSecondAlign <= '0;
        end else if (clkEn && descValid) begin
            capSizeSelect <= outputSizeSelect;
            capFirstGranule <= firstGranuleSelect;
            capSecondGranule <= secondGranuleSelect;
            capFirstAlign <= firstAlignBits;
            capSecondAlign <= secondAlignBits;
        end
    end

    // Disable bits count only where the feature exists, for either format
    assign hadFirst = HIER_DISABLE_IMPL && cdWord[cd_upper_pkg::FIRST_HAD_BIT];
    assign hadSecond = HIER_DISABLE_IMPL && !hypOrMon &&
        cdWord[cd_upper_pkg::SECOND_HAD_BIT];

    // Base decoders, one per table
    table_base_check #(
        .FIELD_W(cd_upper_pkg::BASE_FIELD_W)
    ) firstCheck (
        .baseField(cdWord[cd_upper_pkg::FIRST_BASE_HI:cd_upper_pkg::FIRST_BASE_LO]),
        .alignBits(capFirstAlign),
        .granule(capFirstGranule),
        .outputBits(outputBits),
        .is52(is52),
        .walkDisable(capFirstDisable),
        .firstRevision(FIRST_REVISION),
        .alignedBase(next_firstBase),
        .baseIllegal(firstIllegal)
    );
    // Second table is unreachable at hypervisor or monitor level
    table_base_check #(
        .FIELD_W(cd_upper_pkg::BASE_FIELD_W)
    ) secondCheck (
        .baseField(cdWord[cd_upper_pkg::SECOND_BASE_HI:cd_upper_pkg::SECOND_BASE_LO]),
        .alignBits(capSecondAlign),
        .granule(capSecondGranule),
        .outputBits(outputBits),
        .is52(is52),
        .walkDisable(capSecondDisable || hypOrMon),
        .firstRevision(FIRST_REVISION),
        .alignedBase(next_secondBase),
        .baseIllegal(secondIllegal)
    );

    // Reserved-zero bits that make the descriptor bad when set
    always_comb begin
        reservedSet = 1'b0;
        if (hypOrMon && cdWord[cd_upper_pkg::SECOND_NS_BIT]) begin
            reservedSet = 1'b1;
        end
        if (hypOrMon && HIER_DISABLE_IMPL && cdWord[cd_upper_pkg::SECOND_HAD_BIT]) begin
            reservedSet = 1'b1;
        end
    end

    // Any illegal base or set reserved bit condemns the whole descriptor
    assign anyBad = firstIllegal || secondIllegal || reservedSet;

    // Decode strobe and error; the error stands until the next decode
    // so software can read it after the aborted transfer has gone
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            decodeValid <= 1'b0;
            badDescriptorError <= 1'b0;
            abortTransaction <= 1'b0;
        end else if (clkEn) begin
            decodeValid <= pendingDecode;
            abortTransaction <= pendingDecode && anyBad;
            if (pendingDecode) begin
                badDescriptorError <= anyBad;
            end
        end
    end

    // Aligned bases; a disabled or unreachable table reports zero
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            firstTableBase <= '0;
            secondTableBase <= '0;
        end else if (clkEn && pendingDecode) begin
            firstTableBase <= capFirstDisable ? '0 : next_firstBase;
            secondTableBase <= (capSecondDisable || hypOrMon) ? '0 : next_secondBase;
        end
    end

    // Fetch security of the starting-level tables; secure entries only
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            firstStartNonsecure <= 1'b0;
            secondStartNonsecure <= 1'b0;
        end else if (clkEn && pendingDecode) begin
            // Non-secure entries always fetch non-secure, bits ignored
            firstStartNonsecure <= capSecure ?
                cdWord[cd_upper_pkg::FIRST_NS_BIT] : 1'b1;
            secondStartNonsecure <= capSecure ?
                (cdWord[cd_upper_pkg::SECOND_NS_BIT] && !hypOrMon) : 1'b1;
        end
    end

    // Hierarchical attribute ignores handed to the walker
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            firstIgnoreHierPerm <= 1'b0;
            secondIgnoreHierPerm <= 1'b0;
            firstIgnoreLowPermPxn <= 1'b0;
            secondIgnoreLowPermPxn <= 1'b0;
        end else if (clkEn && pendingDecode) begin
            // Same meaning for short and long formats, so longFormat is unused here
            firstIgnoreHierPerm <= hadFirst;
            secondIgnoreHierPerm <= hadSecond;
            firstIgnoreLowPermPxn <= hadFirst && hypOrMon;
            secondIgnoreLowPermPxn <= 1'b0;
        end
    end

    // Leaf hardware-use selectors, gated by support and disable bits
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            firstHwUseMask <= '0;
            secondHwUseMask <= '0;
        end else if (clkEn && pendingDecode) begin
            // First revision reserves these bits, so they never take effect
            if (PAGE_HW_ATTR_IMPL && !FIRST_REVISION && hadFirst) begin
                firstHwUseMask <= cdWord[cd_upper_pkg::FIRST_HWU_LO +: 4];
            end else begin
                firstHwUseMask <= '0;
            end
            if (PAGE_HW_ATTR_IMPL && !FIRST_REVISION && hadSecond) begin
                secondHwUseMask <= cdWord[cd_upper_pkg::SECOND_HWU_LO +: 4];
            end else begin
                secondHwUseMask <= '0;
            end
        end
    end

    // Auxiliary words pass through untouched; zero is their neutral value
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            auxAttrLow <= '0;
            auxAttrHigh <= '0;
        end else if (clkEn && pendingDecode) begin
            auxAttrLow <= cdWord[cd_upper_pkg::AUX_LOW_LO +: 32];
            auxAttrHigh <= cdWord[cd_upper_pkg::AUX_HIGH_LO +: 32];
        end
    end

    // Attribute byte selection; index picks one of eight bytes
    assign attrWords = {cdWord[cd_upper_pkg::ATTR_HIGH_LO +: 32],
        cdWord[cd_upper_pkg::ATTR_LOW_LO +: 32]};
    assign next_attrByte = attrWords[attributeIndex * cd_upper_pkg::ATTR_BYTE_W +:
        cd_upper_pkg::ATTR_BYTE_W];

    // Lookup answer one cycle after the request; same table for both bases
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            attrValid <= 1'b0;
            attrByte <= '0;
            attrIsReservedDevice <= 1'b0;
            attrDeviceType <= cd_upper_pkg::DEV_NGNRNE;
        end else if (clkEn) begin
            attrValid <= lookupValid && cdLoaded;
            if (lookupValid) begin
                attrByte <= next_attrByte;
                // Upper nibble zero with RW nonzero is a reserved device code
                attrIsReservedDevice <= (next_attrByte[7:4] == 4'h0) &&
                    (next_attrByte[1:0] != 2'h0);
                attrDeviceType <= next_attrByte[3:2];
            end
        end
    end
endmodule // context_descriptor_upper_fields

// File: tb/context_descriptor_upper_fields_asserts.sv
// Checker for the descriptor upper-field decoder.
// Assumes it is bound to the decoder and sees only its ports.
`timescale 1ns/100ps
module cd_upper_checker (
    // Clock, reset and inputs
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic clkEn,
    input wire logic descValid,
    input wire logic [cd_upper_pkg::CD_WIDTH-1:0] contextDescriptor,
    input wire logic secureStreamEntry,
    input wire cd_upper_pkg::level_t streamExceptionLevel,
    input wire logic lookupValid,
    input wire logic [cd_upper_pkg::ATTR_INDEX_W-1:0] attributeIndex,
    // Decoded outputs
    input wire logic decodeValid,
    input wire logic badDescriptorError,
    input wire logic abortTransaction,
    input wire logic firstStartNonsecure,
    input wire logic secondStartNonsecure,
    input wire logic firstIgnoreHierPerm,
    input wire logic firstIgnoreLowPermPxn,
    input wire logic secondIgnoreHierPerm,
    input wire logic secondIgnoreLowPermPxn,
    input wire logic [3:0] firstHwUseMask,
    input wire logic [3:0] secondHwUseMask,
    input wire logic [31:0] auxAttrLow,
    input wire logic [31:0] auxAttrHigh,
    input wire logic attrValid,
    input wire logic [cd_upper_pkg::ATTR_BYTE_W-1:0] attrByte,
    input wire logic attrIsReservedDevice,
    input wire logic [1:0] attrDeviceType
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    logic [cd_upper_pkg::CD_WIDTH-1:0] lastCd;
    logic loaded;
    wire [cd_upper_pkg::CD_WIDTH-1:0] cd = contextDescriptor;
    wire upper = streamExceptionLevel >= cd_upper_pkg::LEVEL_HYP;
    wire [7:0] attrSel = lastCd[192 + 8 * attributeIndex +: 8];
    // Last captured descriptor; lookups read it, not the one in flight
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            loaded <= 1'b0;
            lastCd <= '0;
        end else if (descValid && clkEn) begin
            loaded <= 1'b1;
            lastCd <= contextDescriptor;
        end
    end
    a_decode_abort_pair: assert property (
        descValid && clkEn ##1 clkEn |=> decodeValid && abortTransaction == badDescriptorError)
        else $error("decode answer or abort wrong");
    a_first_ns: assert property (
        decodeValid |-> firstStartNonsecure == ($past(secureStreamEntry, 2) ? $past(cd[64], 2) : 1'b1))
        else $error("first start fetch attribute wrong");
    a_second_ns: assert property (
        decodeValid && !$past(upper, 2) |->
        secondStartNonsecure == ($past(secureStreamEntry, 2) ? $past(cd[128], 2) : 1'b1))
        else $error("second start fetch attribute wrong");
    a_hier_disable: assert property (
        decodeValid |-> firstIgnoreHierPerm == $past(cd[65], 2) &&
        firstIgnoreLowPermPxn == ($past(cd[65], 2) && $past(upper, 2)))
        else $error("hierarchical disable wrong");
    a_hw_use_first: assert property (
        decodeValid |-> firstHwUseMask == ($past(cd[65], 2) ? $past(cd[127:124], 2) : 4'h0))
        else $error("first hardware-use mask wrong");
    a_hw_use_second: assert property (
        decodeValid && !$past(upper, 2) |->
        secondHwUseMask == ($past(cd[129], 2) ? $past(cd[191:188], 2) : 4'h0))
        else $error("second hardware-use mask wrong");
    a_aux_pass: assert property (
        decodeValid |-> auxAttrLow == $past(cd[287:256], 2) &&
        auxAttrHigh == $past(cd[319:288], 2))
        else $error("auxiliary word wrong");
    a_second_hier: assert property (
        decodeValid |-> secondIgnoreHierPerm == ($past(cd[129], 2) && !$past(upper, 2)) &&
        !secondIgnoreLowPermPxn)
        else $error("second hierarchical disable wrong");
    a_attr_lookup: assert property (
        lookupValid && clkEn && loaded |=> attrValid && attrByte == $past(attrSel))
        else $error("attribute byte wrong");
    a_reserved_dev: assert property (
        attrValid |-> attrIsReservedDevice == (attrByte[7:4] == 4'h0 && attrByte[1:0] != 2'h0) &&
        (!attrIsReservedDevice || attrDeviceType == attrByte[3:2]))
        else $error("reserved device code wrong");
    c_bad: cover property (decodeValid && badDescriptorError);
    c_reserved: cover property (attrValid && attrIsReservedDevice);
    c_upper_had: cover property (decodeValid && firstIgnoreLowPermPxn);
endmodule // cd_upper_checker
bind context_descriptor_upper_fields cd_upper_checker cd_upper_checker_inst (.*);

// File: tb/descriptor_memory.sv
// Memory model that returns a descriptor image after a chosen delay.
// Assumes the bench holds the image steady until it is returned.
`timescale 1ns/100ps
module descriptor_memory (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // Fetch request
    input wire logic fetchReq,
    input wire logic [1:0] delay,
    input wire logic zeroAux,
    input wire logic [319:0] image,
    // Descriptor return
    output logic descValid,
    output logic [319:0] contextDescriptor
);
    logic [1:0] cnt;
    logic pend;
    // Delay count; stale data flips every idle cycle so nobody can lean on it
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            pend <= 1'b0;
            cnt <= 2'h0;
            descValid <= 1'b0;
            contextDescriptor <= '0;
        end else begin
            descValid <= pend && cnt == 2'h0;
            if (fetchReq) begin
                pend <= 1'b1;
                cnt <= delay;
            end else if (pend && cnt != 2'h0) begin
                cnt <= cnt - 2'h1;
            end else if (pend) begin
                pend <= 1'b0;
                contextDescriptor <= zeroAux ? {64'h0, image[255:0]} : image;
            end else begin
                contextDescriptor <= ~contextDescriptor;
            end
        end
    end
endmodule // descriptor_memory

// File: tb/context_descriptor_upper_fields_tb.sv
// Testbench for the descriptor upper-field decoder.
// Assumes the decoder's default parameters; the memory model feeds descriptors.
`timescale 1ns/100ps
module context_descriptor_upper_fields_tb;
    logic sys_clk = 1'b0;
    logic rstn, clkEn, descValid, secureStreamEntry, firstWalkDisable, secondWalkDisable;
    logic longFormat, lookupValid, lookupSecondTable, fetchReq, zeroAux;
    logic decodeValid, badDescriptorError, abortTransaction, attrValid, attrIsReservedDevice;
    logic firstStartNonsecure, secondStartNonsecure, firstIgnoreHierPerm, secondIgnoreHierPerm;
    logic firstIgnoreLowPermPxn, secondIgnoreLowPermPxn;
    cd_upper_pkg::level_t streamExceptionLevel;
    logic [319:0] contextDescriptor, image, img;
    logic [51:0] firstTableBase, secondTableBase;
    logic [31:0] auxAttrLow, auxAttrHigh;
    logic [7:0] attrByte;
    logic [5:0] firstAlignBits, secondAlignBits;
    logic [3:0] firstHwUseMask, secondHwUseMask;
    logic [2:0] outputSizeSelect, attributeIndex;
    logic [1:0] firstGranuleSelect, secondGranuleSelect, delay, attrDeviceType;
    logic [105:0] decQ[$];
    logic [8:0] attQ[$];
    int error_cnt = 0;
    int compares = 0;
    int seed = 32'h7418_6fad;
    int OB[8] = '{32, 36, 40, 42, 44, 48, 52, 52};
    wire [105:0] decGot = {badDescriptorError, abortTransaction, firstTableBase, secondTableBase};
    context_descriptor_upper_fields context_descriptor_upper_fields_inst (.*);
    descriptor_memory descriptor_memory_inst (.*);
    initial forever #20 sys_clk = ~sys_clk;
    task automatic wrap_up();
        $display("Counts: %0d compares, %0d mismatches", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic check(input logic [105:0] got, input logic [105:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // Expected {illegal, aligned base}; range is judged on the raw base
    function automatic logic [52:0] ref_base(logic [47:0] f, logic [5:0] al, logic [1:0] g,
            logic dis);
        logic [51:0] raw;
        logic [5:0] a;
        raw = {f, 4'h0};
        a = (g == cd_upper_pkg::GRAN_64K && outputSizeSelect[2:1] == 2'h3 && al < 6'h6) ? 6'h6 : al;
        if (dis)
            return '0;
        return {(raw >> OB[outputSizeSelect]) != 0 ||
            (g != cd_upper_pkg::GRAN_64K && raw[51:48] != 4'h0), raw & ~((52'h1 << a) - 52'h1)};
    endfunction
    // Random stream settings, walk disables kept rare
    task automatic set_cfg(input logic [31:0] r);
        secureStreamEntry <= r[0];
        streamExceptionLevel <= cd_upper_pkg::level_t'(r[2:1]);
        outputSizeSelect <= r[5:3];
        firstWalkDisable <= r[7:6] == 2'h3;
        secondWalkDisable <= r[9:8] == 2'h3;
        firstGranuleSelect <= r[11:10] == 2'h3 ? 2'h1 : r[11:10];
        secondGranuleSelect <= r[13:12] == 2'h3 ? 2'h1 : r[13:12];
        firstAlignBits <= {2'h0, r[17:14]};
        secondAlignBits <= {2'h0, r[21:18]};
        longFormat <= r[22];
        lookupSecondTable <= r[23];
        delay <= r[25:24];
        zeroAux <= r[26];
    endtask
    task automatic run_desc(input logic [319:0] d);
        logic [52:0] r1, r2;
        logic up;
        int n;
        up = streamExceptionLevel >= cd_upper_pkg::LEVEL_HYP;
        r1 = ref_base(d[115:68], firstAlignBits, firstGranuleSelect, firstWalkDisable);
        r2 = ref_base(d[179:132], secondAlignBits, secondGranuleSelect, secondWalkDisable | up);
        r1[52] = r1[52] | r2[52] | (up & (d[128] | d[129]));
        decQ.push_back({r1[52], r1[52], r1[51:0], r2[51:0]});
        image <= d;
        fetchReq <= 1'b1;
        @(posedge sys_clk);
        fetchReq <= 1'b0;
        for (n = 0; n < 20 && decodeValid !== 1'b1; n++)
            @(negedge sys_clk);
        if (n == 20) begin
            check(106'h1, 106'h0, "decode timeout");
            wrap_up();
        end
        @(posedge sys_clk);
    endtask
    // Result watcher on the falling edge, where outputs have settled
    always @(negedge sys_clk) begin
        if (decodeValid === 1'b1)
            check(decGot, decQ.size() ? decQ.pop_front() : 'x, "decode");
        if (attrValid === 1'b1)
            check({attrIsReservedDevice, attrByte}, attQ.size() ? attQ.pop_front() : 9'hx, "attr");
    end
    initial begin
        rstn = 1'b0;
        clkEn = 1'b1;
        fetchReq = 1'b0;
        lookupValid = 1'b0;
        attributeIndex = 3'h0;
        image = '0;
        set_cfg(32'h0000_0000);
        repeat (4) @(posedge sys_clk);
        rstn <= 1'b1;
        @(posedge sys_clk);
        check({decodeValid, badDescriptorError, attrValid, firstTableBase}, '0, "reset");
        lookupValid <= 1'b1;
        @(posedge sys_clk);
        lookupValid <= 1'b0;
        repeat (3) @(posedge sys_clk);
        $display("test reset and early lookup done");
        for (int k = 0; k < 48; k++) begin
            for (int j = 0; j < 10; j++)
                img[32 * j +: 32] = $random(seed);
            img[115:68] = img[115:68] >> img[4:0];
            img[179:132] = img[179:132] >> img[9:5];
            set_cfg($random(seed));
            @(posedge sys_clk);
            run_desc(img);
        end
        $display("test random descriptors done");
        img[179:68] = '0;
        img[255:192] = 64'hff44_0400_0f0b_0601;
        set_cfg(32'h0000_0000);
        @(posedge sys_clk);
        run_desc(img);
        // Back-to-back lookups over every index and all four reserved device types
        for (int i = 0; i < 8; i++) begin
            attQ.push_back({img[196 + 8 * i +: 4] == 4'h0 && img[192 + 8 * i +: 2] != 2'h0,
                img[192 + 8 * i +: 8]});
            lookupValid <= 1'b1;
            attributeIndex <= i[2:0];
            @(posedge sys_clk);
        end
        lookupValid <= 1'b0;
        @(posedge sys_clk);
        // A lookup while frozen must not answer
        clkEn <= 1'b0;
        lookupValid <= 1'b1;
        @(posedge sys_clk);
        lookupValid <= 1'b0;
        clkEn <= 1'b1;
        repeat (4) @(posedge sys_clk);
        check({104'h0, attQ.size() == 0, decQ.size() == 0}, 106'h3, "queues drained");
        $display("test attribute lookups done");
        wrap_up();
    end
endmodule // context_descriptor_upper_fields_tb
